// *** hdl/ilf_pkg.sv ***
package ilf_pkg;
  // link widths and line geometry
  localparam int ADDR_W         = 30;
  localparam int DATA_W         = 64;
  localparam int WORDS_PER_LINE = 8;
  localparam int DW_PER_LINE    = 4;
  localparam int DW_IDX_W       = 2;
  localparam int LINE_W         = ADDR_W - 3;
  localparam int LINE_BITS      = DW_PER_LINE * DATA_W;
  // sequencing counts in core clock cycles
  localparam int MISS_DETECT_CYCLES = 2;
  localparam int LOOKAHEAD_CYCLES   = 2;
  localparam int COPY_CYCLES        = 3;
  localparam int COPY_DELAY_ALIGNED = 2;
  localparam int COPY_DELAY_TARGET  = 1;
  // reset values of the link-facing flags
  localparam logic RESET_FLAG = 1'h0;

  // request issue sequencer of the cache end
  typedef enum logic [2:0] {
    ISS_IDLE     = 3'h0,
    ISS_DETECT   = 3'h1,
    ISS_REQ      = 3'h2,
    ISS_LOOK     = 3'h3
  } issue_state_t;
endpackage

// *** hdl/line_fill_if.sv ***
`timescale 1ns/1ps
interface line_fill_if;
  // request side, driven by the cache end
  logic                                 req;
  logic                                 req_read;
  logic [ilf_pkg::ADDR_W-1:0]           req_addr;
  // answer side, driven by the bus end
  logic                                 addr_ack;
  logic                                 rd_ack;
  logic [ilf_pkg::DATA_W-1:0]           rd_data;
  logic [ilf_pkg::DW_IDX_W-1:0]         rd_dw;

  modport cache_end (
    output req,
    output req_read,
    output req_addr,
    input  addr_ack,
    input  rd_ack,
    input  rd_data,
    input  rd_dw
  );

  modport bus_end (
    input  req,
    input  req_read,
    input  req_addr,
    output addr_ack,
    output rd_ack,
    output rd_data,
    output rd_dw
  );
endinterface

// *** hdl/bus_interface_unit.sv ***
`timescale 1ns/1ps
module bus_interface_unit (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        ce,
  line_fill_if.bus_end                     lnk,
  output logic [ilf_pkg::ADDR_W-1:0]       mem_addr,
  input  wire logic [ilf_pkg::DATA_W-1:0]  mem_rdata,
  input  wire logic                        mem_ready,
  output logic                             busy
);
  typedef struct packed {
    logic                             active;
    logic [ilf_pkg::LINE_W-1:0]       line;
    logic [ilf_pkg::DW_IDX_W-1:0]     dw;
    logic [ilf_pkg::DW_IDX_W-1:0]     left;
    logic                             pend;
    logic [ilf_pkg::ADDR_W-1:0]       pend_addr;
    logic                             rd_ack;
    logic [ilf_pkg::DATA_W-1:0]       rd_data;
    logic [ilf_pkg::DW_IDX_W-1:0]     rd_dw;
    logic                             busy;
  } biu_state_t;

  biu_state_t                    s_reg;
  biu_state_t                    s_next;
  logic                          start_now;
  logic                          pend_now;
  logic [ilf_pkg::ADDR_W-1:0]    pend_addr_now;
  logic [ilf_pkg::LINE_W-1:0]    cur_line;
  logic [ilf_pkg::DW_IDX_W-1:0]  cur_dw;
  logic [ilf_pkg::DW_IDX_W-1:0]  cur_left;
  logic                          fetch;

  // a second request is taken while a line is in flight and parked until it ends
  assign lnk.addr_ack = lnk.req & lnk.req_read & ~s_reg.pend;
  assign start_now    = lnk.addr_ack & ~s_reg.active;
  assign pend_now     = s_reg.pend | (lnk.addr_ack & s_reg.active);
  assign pend_addr_now = s_reg.pend ? s_reg.pend_addr : lnk.req_addr;
  assign cur_line     = start_now ? lnk.req_addr[ilf_pkg::ADDR_W-1:3] : s_reg.line;
  assign cur_dw       = start_now ? lnk.req_addr[2:1] : s_reg.dw;
  assign cur_left     = start_now ? 2'(ilf_pkg::DW_PER_LINE - 1) : s_reg.left;
  assign fetch        = (s_reg.active | start_now) & mem_ready;
  assign mem_addr     = {cur_line, cur_dw, 1'h0};

  // doubleword walk: target first, then wrap upward within the line
  always_comb begin
    s_next = s_reg;
    s_next.rd_ack = fetch;
    if (fetch) begin
      s_next.rd_data = mem_rdata;
      s_next.rd_dw   = cur_dw;
    end
    if (start_now) begin
      s_next.active = 1'h1;
      s_next.dw     = cur_dw;
      s_next.line   = cur_line;
      s_next.left   = cur_left;
    end
    if (lnk.addr_ack && s_reg.active) begin
      s_next.pend      = 1'h1;
      s_next.pend_addr = lnk.req_addr;
    end
    if (fetch) begin
      s_next.dw = cur_dw + 2'h1;
      if (cur_left == 2'h0) begin
        // all four doublewords sent; parked line follows back to back
        s_next.active = pend_now;
        if (pend_now) begin
          s_next.line = pend_addr_now[ilf_pkg::ADDR_W-1:3];
          s_next.dw   = pend_addr_now[2:1];
          s_next.left = 2'(ilf_pkg::DW_PER_LINE - 1);
          s_next.pend = 1'h0;
        end
      end else begin
        s_next.left = cur_left - 2'h1;
      end
    end
    s_next.busy = s_next.active | s_next.pend;
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign lnk.rd_ack  = s_reg.rd_ack;
  assign lnk.rd_data = s_reg.rd_data;
  assign lnk.rd_dw   = s_reg.rd_dw;
  assign busy        = s_reg.busy;
endmodule

// *** hdl/instruction_cache_unit.sv ***
`timescale 1ns/1ps
// Behaviour
// - two detect cycles, then line request
// - bus unit acks at once, streams four doublewords
// - forward each doubleword one cycle after arrival
// - full cacheable line copied in three cycles
// - offset target forwarded; copy one cycle earlier
// - pipelined mode prefetches next line early
// - second line follows completion of first
// - cacheable prefetched line copied, not forwarded
// - non-pipelined next request only after miss
// - quick second line delivered, accepted back-to-back
// - non-cacheable line forwarded, never copied
// - bus unit always sends whole line
// - new line overwrites fill buffer, then forwarded
// - target word first, then wrapping ascending
// - received doubleword latched next cycle
module instruction_cache_unit (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          ce,
  line_fill_if.cache_end                     lnk,
  input  wire logic                          pipelined,
  input  wire logic                          miss_valid,
  input  wire logic [ilf_pkg::ADDR_W-1:0]    miss_addr,
  input  wire logic                          miss_cacheable,
  output logic                               miss_ready,
  output logic                               fwd_valid,
  output logic [ilf_pkg::ADDR_W-1:0]         fwd_addr,
  output logic [ilf_pkg::DATA_W-1:0]         fwd_data,
  output logic                               copy_valid,
  output logic [1:0]                         copy_step,
  output logic [ilf_pkg::LINE_W-1:0]         copy_line,
  output logic [ilf_pkg::LINE_BITS-1:0]      copy_data
);
  // whole state of the cache end in one record
  typedef struct packed {
    ilf_pkg::issue_state_t                            st;
    logic [1:0]                                       cnt;
    logic                                             req;
    logic [ilf_pkg::ADDR_W-1:0]                       req_addr;
    logic                                             req_cache;
    logic                                             req_pf;
    logic                                             miss_ready;
    logic [1:0][ilf_pkg::LINE_W-1:0]                  q_line;
    logic [1:0][ilf_pkg::DW_IDX_W-1:0]                q_dw;
    logic [1:0]                                       q_cache;
    logic [1:0]                                       q_pf;
    logic                                             q_wp;
    logic                                             q_rp;
    logic [ilf_pkg::DW_IDX_W-1:0]                     rx_cnt;
    logic [ilf_pkg::DW_PER_LINE-1:0][ilf_pkg::DATA_W-1:0] fill_buf;
    logic                                             fwd_valid;
    logic [ilf_pkg::ADDR_W-1:0]                       fwd_addr;
    logic [ilf_pkg::DATA_W-1:0]                       fwd_data;
    logic                                             copy_pend;
    logic                                             copy_valid;
    logic [1:0]                                       copy_step;
    logic [ilf_pkg::LINE_W-1:0]                       copy_line;
    logic [ilf_pkg::LINE_BITS-1:0]                    copy_data;
  } icu_state_t;

  // registered state and the value it takes at the next edge
  icu_state_t  s_reg;
  icu_state_t  s_next;
  logic        accept;
  logic        head_last;
  logic        head_skip_fwd;
  logic [ilf_pkg::LINE_W-1:0] next_line;

  // handshake taken, head line complete, prefetch skip and next line number
  assign accept        = s_reg.req & lnk.addr_ack;
  assign head_last     = s_reg.rx_cnt == 2'(ilf_pkg::DW_PER_LINE - 1);
  assign head_skip_fwd = s_reg.q_cache[s_reg.q_rp] & s_reg.q_pf[s_reg.q_rp];
  assign next_line     = s_reg.req_addr[ilf_pkg::ADDR_W-1:3] + 27'h1;

  always_comb begin
    s_next = s_reg;
    s_next.fwd_valid = 1'h0;

    // request issue: detect, request, optional lookahead of the next line
    case (s_reg.st)
      ilf_pkg::ISS_IDLE: begin
        // a miss is taken only here, so a line is asked for after its miss
        if (miss_valid) begin
          s_next.st        = ilf_pkg::ISS_DETECT;
          s_next.cnt       = 2'(ilf_pkg::MISS_DETECT_CYCLES - 1);
          s_next.req_addr  = miss_addr;
          s_next.req_cache = miss_cacheable;
          s_next.req_pf    = 1'h0;
        end
      end
      ilf_pkg::ISS_DETECT: begin
        // count the miss detect cycles before raising the request
        if (s_reg.cnt == 2'h0) begin
          s_next.st  = ilf_pkg::ISS_REQ;
          s_next.req = 1'h1;
        end else begin
          s_next.cnt = s_reg.cnt - 2'h1;
        end
      end
      ilf_pkg::ISS_REQ: begin
        // hold the request until the bus end takes it
        if (accept) begin
          s_next.req = 1'h0;
          if (pipelined && !s_reg.req_pf) begin
            s_next.st  = ilf_pkg::ISS_LOOK;
            s_next.cnt = 2'(ilf_pkg::LOOKAHEAD_CYCLES - 2);
          end else begin
            s_next.st  = ilf_pkg::ISS_IDLE;
          end
        end
      end
      ilf_pkg::ISS_LOOK: begin
        // wait out the lookahead, then ask for the following line
        if (s_reg.cnt == 2'h0) begin
          s_next.st       = ilf_pkg::ISS_REQ;
          s_next.req      = 1'h1;
          s_next.req_addr = {next_line, 3'h0};
          s_next.req_pf   = 1'h1;
        end else begin
          s_next.cnt = s_reg.cnt - 2'h1;
        end
      end
      default: begin
        // unused code: fall back to idle with no request
        s_next.st  = ilf_pkg::ISS_IDLE;
        s_next.req = 1'h0;
      end
    endcase
    s_next.miss_ready = s_next.st == ilf_pkg::ISS_IDLE;

    // outstanding lines kept in request order
    if (accept) begin
      s_next.q_line[s_reg.q_wp]  = s_reg.req_addr[ilf_pkg::ADDR_W-1:3];
      s_next.q_dw[s_reg.q_wp]    = s_reg.req_addr[2:1];
      s_next.q_cache[s_reg.q_wp] = s_reg.req_cache;
      s_next.q_pf[s_reg.q_wp]    = s_reg.req_pf;
      s_next.q_wp                = ~s_reg.q_wp;
    end

    // running copy into the cache array
    if (s_reg.copy_valid) begin
      if (s_reg.copy_step == 2'(ilf_pkg::COPY_CYCLES - 1)) begin
        s_next.copy_valid = 1'h0;
      end else begin
        s_next.copy_step = s_reg.copy_step + 2'h1;
      end
    end
    if (s_reg.copy_pend) begin
      s_next.copy_pend  = 1'h0;
      s_next.copy_valid = 1'h1;
      s_next.copy_step  = 2'h0;
    end

    // receive: latch, forward, and on the last doubleword hand the line over
    if (lnk.rd_ack) begin
      s_next.fill_buf[lnk.rd_dw] = lnk.rd_data;
      // a cacheable prefetched line goes to the cache unforwarded
      if (!head_skip_fwd) begin
        s_next.fwd_valid = 1'h1;
        s_next.fwd_addr  = {s_reg.q_line[s_reg.q_rp], lnk.rd_dw, 1'h0};
        s_next.fwd_data  = lnk.rd_data;
      end
      s_next.rx_cnt = s_reg.rx_cnt + 2'h1;
      // last doubleword: pop the head line and schedule its copy
      if (head_last) begin
        s_next.q_rp = ~s_reg.q_rp;
        // a non-cacheable line stays in the fill buffer only
        if (s_reg.q_cache[s_reg.q_rp]) begin
          s_next.copy_line = s_reg.q_line[s_reg.q_rp];
          s_next.copy_data = s_next.fill_buf;
          // offset target copies one cycle earlier than an aligned one
          if (s_reg.q_dw[s_reg.q_rp] != 2'h0 && ilf_pkg::COPY_DELAY_TARGET == 1) begin
            s_next.copy_valid = 1'h1;
            s_next.copy_step  = 2'h0;
          end else begin
            s_next.copy_pend  = ilf_pkg::COPY_DELAY_ALIGNED == 2;
            s_next.copy_valid = ilf_pkg::COPY_DELAY_ALIGNED == 1;
            s_next.copy_step  = 2'h0;
          end
        end
      end
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg            <= '0;
      s_reg.st         <= ilf_pkg::ISS_IDLE;
      s_reg.miss_ready <= 1'h1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // link and user outputs straight from the state register, except req_read tied high
  assign lnk.req      = s_reg.req;
  assign lnk.req_read = 1'h1;
  assign lnk.req_addr = s_reg.req_addr;
  assign miss_ready   = s_reg.miss_ready;
  assign fwd_valid    = s_reg.fwd_valid;
  assign fwd_addr     = s_reg.fwd_addr;
  assign fwd_data     = s_reg.fwd_data;
  assign copy_valid   = s_reg.copy_valid;
  assign copy_step    = s_reg.copy_step;
  assign copy_line    = s_reg.copy_line;
  assign copy_data    = s_reg.copy_data;
endmodule

// *** tb/line_fill_sva.sv ***
`timescale 1ns/1ps
module line_fill_sva (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        req,
  input wire logic        req_read,
  input wire logic [29:0] req_addr,
  input wire logic        addr_ack,
  input wire logic        rd_ack,
  input wire logic [1:0]  rd_dw
);
  logic [1:0] cnt_reg;
  logic [1:0] prev_reg;
  logic [1:0] q0_reg;
  logic [1:0] q1_reg;
  logic [1:0] out_reg;
  wire        acc  = req && addr_ack;
  wire        done = rd_ack && cnt_reg == 2'h3;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // tracks doubleword count, accepted lines and their target doublewords
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg  <= 2'h0;
      prev_reg <= 2'h0;
      q0_reg   <= 2'h0;
      q1_reg   <= 2'h0;
      out_reg  <= 2'h0;
    end else begin
      if (rd_ack) begin
        cnt_reg  <= cnt_reg + 2'h1;
        prev_reg <= rd_dw;
      end
      if (acc && (out_reg == 2'h0 || (done && out_reg == 2'h1))) q0_reg <= req_addr[2:1];
      else if (done) q0_reg <= q1_reg;
      if (acc) q1_reg <= req_addr[2:1];
      out_reg <= out_reg + {1'b0, acc} - {1'b0, done};
    end
  end

  chk_read_only: assert property (req |-> req_read) else $error("write request seen");
  chk_req_hold: assert property (req && !addr_ack |=> req && $stable(req_addr)) else $error("request dropped");
  chk_req_drop: assert property (req && addr_ack |=> !req) else $error("request repeated after ack");
  chk_first_dw: assert property (rd_ack && cnt_reg == 2'h0 |-> rd_dw == q0_reg) else $error("target not first");
  chk_wrap_order: assert property (rd_ack && cnt_reg != 2'h0 |-> rd_dw == prev_reg + 2'h1) else $error("bad order");
  chk_fast_start: assert property (acc && out_reg == 2'h0 |=> rd_ack) else $error("late first data");
  chk_whole_burst: assert property (rd_ack && cnt_reg != 2'h3 |=> rd_ack) else $error("line cut");
  chk_back_to_back: assert property (done && out_reg == 2'h2 |=> rd_ack) else $error("gap between lines");
  chk_no_stray: assert property (rd_ack |-> out_reg != 2'h0) else $error("data without request");
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic         clk, nrst, pipelined, miss_valid, miss_cacheable, act, ce, busy, ep, es;
  logic [29:0]  miss_addr, mem_addr, fwd_addr;
  logic         miss_ready, fwd_valid, copy_valid;
  logic [1:0]   copy_step;
  logic [26:0]  copy_line;
  logic [63:0]  fwd_data;
  logic [255:0] copy_data;
  logic [30:0]  ef [32];
  logic [30:0]  ea [32];
  logic [29:0]  ec [32];
  int           fails, n_tests, cyc, base, wd, r;

  line_fill_if lnk ();
  instruction_cache_unit instruction_cache_unit_inst (.clk(clk), .nrst(nrst), .ce(ce), .lnk(lnk),
    .pipelined(pipelined), .miss_valid(miss_valid), .miss_addr(miss_addr), .miss_cacheable(miss_cacheable),
    .miss_ready(miss_ready), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .fwd_data(fwd_data),
    .copy_valid(copy_valid), .copy_step(copy_step), .copy_line(copy_line), .copy_data(copy_data));
  bus_interface_unit bus_interface_unit_inst (.clk(clk), .nrst(nrst), .ce(ce), .lnk(lnk), .mem_addr(mem_addr),
    .mem_rdata(md(mem_addr)), .mem_ready(1'h1), .busy(busy));
  line_fill_sva line_fill_sva_inst (.clk(clk), .nrst(nrst), .req(lnk.req), .req_read(lnk.req_read),
    .req_addr(lnk.req_addr), .addr_ack(lnk.addr_ack), .rd_ack(lnk.rd_ack), .rd_dw(lnk.rd_dw));

  // memory contents derived from the doubleword address
  function automatic logic [63:0] md(input logic [29:0] a);
    return {2'h0, a, 2'h3, ~a};
  endfunction

  task automatic chk(input logic [255:0] s, input logic [255:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // expected forwards from cycle s+1, copy after the last doubleword
  task automatic fill(input logic [26:0] l, input logic [1:0] t, input int s, input logic fw, input logic cp);
    for (int i = 0; i < 4; i++) if (fw) ef[s+1+i] = {1'b1, l, 2'(t + i), 1'b0};
    for (int j = 0; j < 3; j++) if (cp) ec[s+5-(t != 2'h0)+j] = {2'(j), 1'b1, l};
  endtask

  // one demand miss, an optional lookahead or quick second miss
  task automatic scen(input logic [29:0] a, input logic c, input logic p, input logic sec);
    ef = '{default: '0};
    ea = '{default: '0};
    ec = '{default: '0};
    ea[3] = {1'b1, a};
    fill(a[29:3], a[2:1], 4, 1'b1, c);
    if (p || sec) ea[p ? 5 : 7] = {1'b1, a[29:3] + 27'h1, 3'h0};
    if (p || sec) fill(a[29:3] + 27'h1, 2'h0, 8, sec || !c, c);
    @(posedge clk);
    #1;
    base = cyc;
    act = 1'b1;
    miss_valid = 1'b1;
    miss_addr = a;
    miss_cacheable = c;
    pipelined = p;
    ep = p;
    es = sec;
    @(posedge clk);
    #1 miss_valid = 1'b0;
    if (sec) begin
      repeat (3) @(posedge clk);
      #1;
      miss_valid = 1'b1;
      miss_addr = {a[29:3] + 27'h1, 3'h0};
      @(posedge clk);
      #1 miss_valid = 1'b0;
    end
    repeat (24) @(posedge clk);
    #1 act = 1'b0;
  endtask

  // per-cycle comparison of link accepts, forwards and copies
  always @(posedge clk) begin
    r = cyc - base;
    cyc++;
    wd++;
    if (wd > 2000) begin
      fails++;
      close_out();
    end else if (act && r >= 0 && r < 32) begin
      chk(lnk.req && lnk.addr_ack, ea[r][30]);
      if (ea[r][30]) chk(lnk.req_addr, ea[r][29:0]);
      chk(fwd_valid, ef[r][30]);
      chk(miss_ready, !((r >= 1 && r <= 3) || (ep && (r == 4 || r == 5)) || (es && r >= 5 && r <= 7)));
      chk(busy, (r >= 4 && r <= 6) || (ep && r >= 7 && r <= 10) || (es && r >= 8 && r <= 10));
      if (ef[r][30]) chk(fwd_addr, ef[r][29:0]);
      if (ef[r][30]) chk(fwd_data, md(ef[r][29:0]));
      chk(copy_valid, ec[r][27]);
      if (ec[r][27]) chk(copy_line, ec[r][26:0]);
      if (ec[r][27]) chk(copy_step, ec[r][29:28]);
      if (ec[r][27]) chk(copy_data, {md({ec[r][26:0], 3'h6}), md({ec[r][26:0], 3'h4}),
        md({ec[r][26:0], 3'h2}), md({ec[r][26:0], 3'h0})});
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // scenarios: aligned, offset target, pipelined, non-cacheable
  initial begin
    nrst = 1'b0;
    act = 1'b0;
    miss_valid = 1'b0;
    pipelined = 1'b0;
    miss_cacheable = 1'b0;
    miss_addr = 30'h0;
    ce = 1'b1;
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    scen(30'h00000100, 1'b1, 1'b0, 1'b1);
    scen(30'h00000216, 1'b1, 1'b0, 1'b0);
    scen(30'h00000300, 1'b1, 1'b1, 1'b0);
    scen(30'h00000414, 1'b0, 1'b1, 1'b0);
    scen(30'h0000052a, 1'b0, 1'b0, 1'b1);
    // clock enable low: a waiting miss must not be taken
    @(posedge clk);
    #1 ce = 1'b0;
    miss_valid = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(lnk.req, 1'b0);
    chk(miss_ready, 1'b1);
    miss_valid = 1'b0;
    ce = 1'b1;
    close_out();
  end
endmodule
